// ==== verilog/atr_top.sv ====
/*
 * Converter trigger, result and input-buffer-disable register block.
 * Assumes a register port on mclk, analog core outside, pins async.
 */
// Added by the designer: the strobed register port.
module atr_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:1] trig_flags,
    input wire logic conv_valid,
    input wire logic [9:0] conv_data,
    input wire logic conv_busy,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_in_gated,
    output logic [7:0] buffer_off,
    output logic [1:0] cmp_buffer_off,
    output logic converter_enable,
    output logic conv_start,
    output logic irq
);
    logic [7:0] buf_q, buf_d;
    logic [7:0] ca_q, ca_d;
    logic [7:0] cb_q, cb_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] pin_s1_q, pin_s2_q, gated_q;
    logic [15:0] result_word;
    logic [7:0] src_flags;
    logic updated, trig_start, rd_lo, rd_hi;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign rd_lo = reg_rd && hit(reg_addr, atr_pkg::OFF_RES_LO);
    assign rd_hi = reg_rd && hit(reg_addr, atr_pkg::OFF_RES_HI);
    assign src_flags = {trig_flags, ca_q[atr_pkg::CA_DONE_BIT]};
    assign converter_enable = ca_q[atr_pkg::CA_EN_BIT];

    atr_trig_sel u_trig (
        .mclk(mclk),
        .reset_n(reset_n),
        .auto_trigger_en(ca_q[atr_pkg::CA_ATE_BIT]),
        .converter_enable(ca_q[atr_pkg::CA_EN_BIT]),
        .trigger_source_sel(cb_q[2:0]),
        .src_flags(src_flags),
        .trig_start(trig_start)
    );

    atr_result u_res (
        .mclk(mclk),
        .reset_n(reset_n),
        .conv_valid(conv_valid),
        .conv_data(conv_data),
        .rd_lo(rd_lo),
        .rd_hi(rd_hi),
        .left_adjust_sel(cb_q[atr_pkg::CB_LEFT_BIT]),
        .result_word(result_word),
        .updated(updated)
    );

    // Register writes, flags with set winning over clear
    always_comb begin
        buf_d = buf_q;
        ca_d = ca_q;
        cb_d = cb_q;
        stat_d = stat_q;
        mask_d = mask_q;
        conv_start = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                atr_pkg::OFF_BUF_DIS: buf_d = reg_wdata;
                atr_pkg::OFF_CTRL_A: begin
                    ca_d = {reg_wdata[7], 1'b0, reg_wdata[5], ca_q[4],
                        reg_wdata[3:0]};
                    if (reg_wdata[atr_pkg::CA_DONE_BIT]) begin
                        ca_d[atr_pkg::CA_DONE_BIT] = 1'b0;
                    end
                    conv_start = reg_wdata[atr_pkg::CA_BUSY_BIT]
                        && reg_wdata[atr_pkg::CA_EN_BIT];
                end
                atr_pkg::OFF_CTRL_B: cb_d = {reg_wdata[7], 4'h0,
                    reg_wdata[2:0]};
                atr_pkg::OFF_IRQ_STAT: stat_d = stat_q & ~reg_wdata[1:0];
                atr_pkg::OFF_IRQ_MASK: mask_d = reg_wdata[1:0];
                default: ;
            endcase
        end
        if (trig_start) begin
            conv_start = 1'b1;
            stat_d[atr_pkg::IRQ_TRIG_BIT] = 1'b1;
        end
        if (updated) begin
            ca_d[atr_pkg::CA_DONE_BIT] = 1'b1;
            stat_d[atr_pkg::IRQ_DONE_BIT] = 1'b1;
        end
        ca_d[atr_pkg::CA_BUSY_BIT] = conv_busy;
    end

    // Read data, one cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                atr_pkg::OFF_BUF_DIS: rdata_d = buf_q;
                atr_pkg::OFF_RES_LO: rdata_d = result_word[7:0];
                atr_pkg::OFF_RES_HI: rdata_d = result_word[15:8];
                atr_pkg::OFF_CTRL_A: rdata_d = ca_q;
                atr_pkg::OFF_CTRL_B: rdata_d = cb_q;
                atr_pkg::OFF_IRQ_STAT: rdata_d = {6'h00, stat_q};
                atr_pkg::OFF_IRQ_MASK: rdata_d = {6'h00, mask_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(stat_q & mask_q);
    assign buffer_off = buf_q;
    assign cmp_buffer_off = buf_q[atr_pkg::CMP_PIN_CNT-1:0];
    assign pin_in_gated = gated_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            buf_q <= atr_pkg::RST_BUF_DIS;
            ca_q <= atr_pkg::RST_CTRL;
            cb_q <= atr_pkg::RST_CTRL;
            stat_q <= 2'h0;
            mask_q <= 2'h0;
            rdata_q <= 8'h00;
        end else begin
            buf_q <= buf_d;
            ca_q <= ca_d;
            cb_q <= cb_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // Pin sync then gating by disable bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            gated_q <= 8'h00;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            gated_q <= pin_s2_q & ~buf_q;
        end
    end
endmodule

// ==== include/atr_pkg.sv ====
/*
 * Package for the converter trigger and result register block.
 * Assumes an 8-bit register port on mclk, offsets as byte addresses.
 */
package atr_pkg;
    localparam logic [7:0] OFF_BUF_DIS = 8'h17;
    localparam logic [7:0] OFF_RES_LO = 8'h19;
    localparam logic [7:0] OFF_RES_HI = 8'h1a;
    localparam logic [7:0] OFF_CTRL_B = 8'h1c;
    localparam logic [7:0] OFF_CTRL_A = 8'h1d;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1e;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1f;
    localparam logic [7:0] RST_BUF_DIS = 8'h00;
    localparam logic [9:0] RST_RESULT = 10'h000;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam int CA_EN_BIT = 7;
    localparam int CA_BUSY_BIT = 6;
    localparam int CA_ATE_BIT = 5;
    localparam int CA_DONE_BIT = 4;
    localparam int CB_LEFT_BIT = 7;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_TRIG_BIT = 1;
    localparam int CMP_PIN_CNT = 2;
    typedef enum logic [2:0] {
        ATR_SRC_FREE, ATR_SRC_CMP, ATR_SRC_EXT0, ATR_SRC_T0_CMPA,
        ATR_SRC_T0_OVF, ATR_SRC_T0_CMPB, ATR_SRC_PCINT0, ATR_SRC_T0_CAP
    } atr_src_e;
endpackage

// ==== verilog/atr_trig_sel.sv ====
/*
 * Auto-trigger source selector and edge detector.
 * Assumes flags are synchronous to mclk.
 */
module atr_trig_sel (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic auto_trigger_en,
    input wire logic converter_enable,
    input wire logic [2:0] trigger_source_sel,
    input wire logic [7:0] src_flags,
    output logic trig_start
);
    logic sel_q, sel_d;
    logic [2:0] src_q, src_d;
    logic cur;

    always_comb begin
        cur = src_flags[trigger_source_sel];
        src_d = trigger_source_sel;
        sel_d = cur;
        trig_start = 1'b0;
        // Edge of the selected flag, including switching sources
        if (auto_trigger_en && converter_enable && cur && !sel_q) begin
            trig_start = 1'b1;
        end
        // Entering free running never makes an edge
        if (trigger_source_sel == 3'(atr_pkg::ATR_SRC_FREE)
                && src_q != 3'(atr_pkg::ATR_SRC_FREE)) begin
            trig_start = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q <= 1'b0;
            src_q <= 3'h0;
        end else begin
            sel_q <= sel_d;
            src_q <= src_d;
        end
    end
endmodule

// ==== verilog/atr_result.sv ====
/*
 * Conversion result holder with low-byte lock and adjust formatting.
 * Assumes conv_valid is a one-cycle pulse on mclk.
 */
module atr_result (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic conv_valid,
    input wire logic [9:0] conv_data,
    input wire logic rd_lo,
    input wire logic rd_hi,
    input wire logic left_adjust_sel,
    output logic [15:0] result_word,
    output logic updated
);
    logic [9:0] res_q, res_d;
    logic lock_q, lock_d;

    always_comb begin
        res_d = res_q;
        lock_d = lock_q;
        updated = 1'b0;
        if (rd_hi) begin
            lock_d = 1'b0;
        end
        if (rd_lo) begin
            lock_d = 1'b1;
        end
        if (conv_valid && !lock_q) begin
            res_d = conv_data;
            updated = 1'b1;
        end
    end

    // Formatting is live so adjust changes show at once
    always_comb begin
        if (left_adjust_sel) begin
            result_word = {res_q, 6'h00};
        end else begin
            result_word = {6'h00, res_q};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            res_q <= atr_pkg::RST_RESULT;
            lock_q <= 1'b0;
        end else begin
            res_q <= res_d;
            lock_q <= lock_d;
        end
    end
endmodule

// ==== verif/atr_chk.sv ====
/* Port checker for atr_top.
   Assumes one mclk domain and bind by name. */
module atr_chk (
    input logic mclk,
    input logic reset_n,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic [7:0] pin_in_gated,
    input logic [7:0] buffer_off,
    input logic [1:0] cmp_buffer_off,
    input logic converter_enable,
    input logic conv_start,
    input logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("rdata not idle");
    property p_unmap; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read");
    property p_dis_wr;
        reg_wr && reg_addr == 8'h17 |=> buffer_off == $past(reg_wdata);
    endproperty
    a_dis_wr: assert property (p_dis_wr)
        else $error("disable write");
    property p_gate; (pin_in_gated & buffer_off & $past(buffer_off)) == 0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("pin not gated");
    property p_cmp; cmp_buffer_off == buffer_off[1:0]; endproperty
    a_cmp: assert property (p_cmp)
        else $error("cmp gate");
    property p_start_en; conv_start && !reg_wr |-> converter_enable;
    endproperty
    a_start_en: assert property (p_start_en)
        else $error("start while off");
    property p_edge;
        conv_start && !reg_wr && !$past(reg_wr) |-> !$past(conv_start);
    endproperty
    a_edge: assert property (p_edge)
        else $error("level start");
    property p_en_chg;
        $changed(converter_enable) |-> $past(reg_wr && reg_addr == 8'h1d);
    endproperty
    a_en_chg: assert property (p_en_chg)
        else $error("enable moved");
    c_start: cover property (conv_start);
    c_irq: cover property ($rose(irq));
    c_gate: cover property (buffer_off != 0 && pin_in_gated != 0);
endmodule

bind atr_top atr_chk u_chk (.*);

// ==== verif/atr_tb_top.sv ====
/* Directed register-port tests for atr_top.
   Assumes atr_top and atr_chk compiled first. */
module atr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, conv_valid = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, pin_in = 8'hff;
    logic [7:1] trig_flags = 0;
    logic [9:0] conv_data = 0;
    logic conv_busy = 0;
    logic [7:0] reg_rdata, pin_in_gated, buffer_off;
    logic [1:0] cmp_buffer_off;
    logic converter_enable, conv_start, irq;
    int errors = 0, n_checks = 0, cyc = 0;

    atr_top u_dut (.*);

    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            wrap_up();
        end
    end

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 0;
        #1;
        chk(reg_rdata, e);
    endtask

    task conv(input logic [9:0] d);
        @(posedge mclk);
        conv_valid <= 1;
        conv_data <= d;
        @(posedge mclk);
        conv_valid <= 0;
    endtask

    task fl(input logic [7:0] f);
        @(posedge mclk);
        trig_flags <= f[7:1];
        #1;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1;
        rd(8'h17, 8'h00);
        wr(8'h1a, 8'hff);
        rd(8'h19, 8'h00);
        rd(8'h1a, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h17, 8'ha5);
        rd(8'h17, 8'ha5);
        chk(cmp_buffer_off, 8'h01);
        chk(buffer_off, 8'ha5);
        repeat (4) @(posedge mclk);
        #1;
        chk(pin_in_gated, 8'h5a);
        $display("test reset and gating ended");
        conv(10'h2b6);
        rd(8'h1d, 8'h10);
        rd(8'h19, 8'hb6);
        rd(8'h1a, 8'h02);
        wr(8'h1c, 8'h80);
        rd(8'h19, 8'h80);
        rd(8'h1a, 8'had);
        wr(8'h1f, 8'h01);
        #1;
        chk(irq, 8'h01);
        wr(8'h1e, 8'h01);
        #1;
        chk(irq, 8'h00);
        rd(8'h19, 8'h80);
        conv(10'h155);
        rd(8'h1a, 8'had);
        conv(10'h155);
        rd(8'h1a, 8'h55);
        $display("test result ended");
        wr(8'h1d, 8'hb0);
        #1;
        chk(converter_enable, 8'h01);
        for (int s = 1; s < 8; s++) begin
            wr(8'h1c, 8'(s));
            fl(~(8'h01 << s));
            chk(conv_start, 8'h00);
            fl(8'hfe);
            chk(conv_start, 8'h01);
            fl(8'hfe);
            chk(conv_start, 8'h00);
            fl(8'h00);
        end
        wr(8'h1d, 8'h80);
        fl(8'hfe);
        chk(conv_start, 8'h00);
        fl(8'h00);
        wr(8'h1d, 8'ha0);
        wr(8'h1c, 8'h02);
        fl(8'h02);
        wr(8'h1c, 8'h01);
        #1;
        chk(conv_start, 8'h01);
        fl(8'h00);
        conv(10'h001);
        conv_busy <= 1;
        wr(8'h1c, 8'h00);
        #1;
        chk(conv_start, 8'h00);
        rd(8'h1d, 8'hf0);
        rd(8'h1e, 8'h03);
        rd(8'h1f, 8'h01);
        $display("test trigger ended");
        wrap_up();
    end
endmodule
